// [verilog/aclrt_pkg.sv]
package aclrt_pkg;
  // ----------------------------------------------------------------
  // switch register map seen by the host
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTL_SEL   = 8'h6E;
  localparam logic [7:0] OFS_ADR_TRIG  = 8'h6F;
  localparam logic [7:0] OFS_DATA_BYTE = 8'hA0;

  // ----------------------------------------------------------------
  // fields of the indirect control select register
  // ----------------------------------------------------------------
  localparam int         CTL_SPACE_MSB = 7;
  localparam int         CTL_SPACE_LSB = 5;
  localparam int         CTL_DIR_BIT   = 4;
  localparam logic [2:0] SPACE_RULE    = 3'h2;
  localparam logic       DIR_READ      = 1'h1;
  localparam logic       DIR_WRITE     = 1'h0;

  // ----------------------------------------------------------------
  // rule table geometry and indirect offsets
  // ----------------------------------------------------------------
  localparam int         NUM_PORTS     = 5;
  localparam int         NUM_ENTRIES   = 16;
  localparam int         ENTRY_BYTES   = 18;
  localparam int         STAGE_BYTES   = 19;
  localparam logic [7:0] IA_FIRST_RULE = 8'h00;
  localparam logic [7:0] IA_FILT_MODE  = 8'h01;
  localparam logic [7:0] IA_GROUP_HI   = 8'h0C;
  localparam logic [7:0] IA_GROUP_LO   = 8'h0D;
  localparam logic [7:0] IA_RSVD_HI    = 8'h0E;
  localparam logic [7:0] IA_RSVD_LO    = 8'h0F;
  localparam logic [7:0] IA_ENTRY_CTL  = 8'h12;
  localparam logic [7:0] MASK_FIRST    = 8'h0F;
  localparam logic [7:0] MASK_MODE     = 8'h30;
  localparam logic [7:0] MASK_FULL     = 8'hFF;
  localparam int         MODE_LSB      = 4;

  // entry control byte: entry index, write-entry command, reject flag
  localparam int         ECTL_WR_BIT   = 4;
  localparam int         ECTL_REJ_BIT  = 7;

  typedef enum logic [1:0] {
    ACLRT_MODE_OFF,
    ACLRT_MODE_L2,
    ACLRT_MODE_L3,
    ACLRT_MODE_L4
  } aclrt_mode_t;
endpackage

// [verilog/aclrt_bus_if.sv]
interface aclrt_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport dev (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata
  );
endinterface

// [verilog/aclrt_dev.sv]
// Function
// R1 - five ports, sixteen rule entries each
// R2 - host updates whole entries read-modify-write
// R3 - entry read: two control writes, three reads
// R4 - entry write: one control read, three writes
// R5 - control low nibble is port number
// R6 - trigger register gives indirect byte address
// R7 - offsets 0x00-0x0d are entry bytes descending
// R8 - offsets 0x0E, 0x0F reserved, no function
// R9 - offsets 0x10, 0x11 hold byte enables
// R10 - offset 0x12 is entry control and status
// R11 - space 010 selects table, data via 0xA0
// R12 - offset 0x00 low nibble: first rule index
// R13 - offsets 0x0c, 0x0d group rules into sets
// R14 - host always programs first rule index
// R15 - filter mode decode off, L2, L3, L4
// R16 - control bit 4 read, trigger starts access
// R17 - reserved bits read zero, writes ignored
// R18 - invalid port changes nothing, reads zero; an entry control write still sets reject flag bit 7
module aclrt_dev #(
  parameter int NUM_PORTS   = aclrt_pkg::NUM_PORTS,
  parameter int NUM_ENTRIES = aclrt_pkg::NUM_ENTRIES
) (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  aclrt_bus_if.dev          bus,
  input  wire logic [2:0]   lkp_port_i,
  input  wire logic [3:0]   lkp_entry_i,
  output logic              lkp_valid_o,
  output logic [3:0]        first_rule_index_o,
  output aclrt_pkg::aclrt_mode_t filter_mode_o,
  output logic              filter_active_o,
  output logic [15:0]       rule_group_o,
  output logic [15:0]       byte_enable_o
);
  localparam int IDX_W  = 7;
  localparam int DEPTH  = NUM_PORTS * NUM_ENTRIES;
  localparam int EB     = aclrt_pkg::ENTRY_BYTES;
  localparam int SB     = aclrt_pkg::STAGE_BYTES;

  typedef logic [EB-1:0][7:0] aclrt_entry_t;

  typedef struct packed {
    logic [7:0]                 ctl;
    logic [7:0]                 iadr;
    logic [7:0]                 data;
    logic [7:0]                 rdata;
    logic [SB-1:0][7:0]         stage;
    logic                       lkp_valid;
    logic [3:0]                 first;
    aclrt_pkg::aclrt_mode_t     mode;
    logic                       active;
    logic [15:0]                group;
    logic [15:0]                ben;
  } aclrt_dev_state_t;

  aclrt_dev_state_t q;
  aclrt_dev_state_t d;

  // one word per port and entry; 0x0E/0x0F bytes stay zero
  aclrt_entry_t mem [DEPTH];

  logic             mem_we;
  logic [IDX_W-1:0] mem_idx;
  logic [3:0]       port;
  logic             port_ok;
  logic             space_ok;
  logic             is_read;
  logic [IDX_W-1:0] lkp_idx;
  logic             lkp_ok;
  aclrt_entry_t     lkp_word;

  // ----------------------------------------------------------------
  // indirect byte access helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] wr_mask(input logic [7:0] a);
    logic [7:0] m;
    m = aclrt_pkg::MASK_FULL;
    if (a == aclrt_pkg::IA_FIRST_RULE) begin
      m = aclrt_pkg::MASK_FIRST;                                  // [R17]
    end else if (a == aclrt_pkg::IA_FILT_MODE) begin
      m = aclrt_pkg::MASK_MODE;                                   // [R17]
    end else if (a == aclrt_pkg::IA_RSVD_HI ||
                 a == aclrt_pkg::IA_RSVD_LO) begin
      m = 8'h00;                                                  // [R8]
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    d.rdata  = 8'h00;
    mem_we   = 1'b0;
    port     = q.ctl[3:0];                                        // [R5]
    port_ok  = port < 4'(NUM_PORTS);                              // [R18]
    space_ok = q.ctl[aclrt_pkg::CTL_SPACE_MSB:aclrt_pkg::CTL_SPACE_LSB]
               == aclrt_pkg::SPACE_RULE;                          // [R11]
    is_read  = q.ctl[aclrt_pkg::CTL_DIR_BIT] == aclrt_pkg::DIR_READ;
    // port and entry form the table index; port picks the table [R1]
    mem_idx  = {port[2:0], q.stage[SB-1][3:0]};
    if (bus.wr) begin
      unique case (bus.addr)
        aclrt_pkg::OFS_CTL_SEL: begin
          d.ctl = bus.wdata;
        end
        aclrt_pkg::OFS_ADR_TRIG: begin
          d.iadr = bus.wdata;                                     // [R6]
          // a trigger in read direction fetches the byte now [R16]
          if (space_ok && is_read) begin
            if (port_ok && bus.wdata < 8'(SB)) begin
              d.data = q.stage[bus.wdata[4:0]];                   // [R7] [R9]
            end else begin
              d.data = 8'h00;                                     // [R18]
            end
          end
        end
        aclrt_pkg::OFS_DATA_BYTE: begin
          d.data = bus.wdata;
          // write direction: the data byte lands at the armed address
          if (space_ok && !is_read && port_ok) begin              // [R11] [R18]
            if (q.iadr == aclrt_pkg::IA_ENTRY_CTL) begin          // [R10]
              d.stage[SB-1] = {1'b0, 2'b00, 1'b0, bus.wdata[3:0]};
              mem_idx = {port[2:0], bus.wdata[3:0]};
              if (bus.wdata[aclrt_pkg::ECTL_WR_BIT]) begin
                mem_we = 1'b1;                                    // [R2]
              end else begin
                d.stage[EB-1:0] = mem[mem_idx];
              end
            end else if (q.iadr < 8'(EB)) begin
              d.stage[q.iadr[4:0]] = bus.wdata & wr_mask(q.iadr); // [R7] [R9]
            end
          end else if (space_ok && !is_read &&
                       q.iadr == aclrt_pkg::IA_ENTRY_CTL) begin
            d.stage[SB-1][aclrt_pkg::ECTL_REJ_BIT] = 1'b1;        // [R18]
          end
        end
        default: begin
        end
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        aclrt_pkg::OFS_CTL_SEL:   d.rdata = q.ctl;
        aclrt_pkg::OFS_ADR_TRIG:  d.rdata = q.iadr;
        aclrt_pkg::OFS_DATA_BYTE: d.rdata = q.data;
        default:                  d.rdata = 8'h00;
      endcase
    end
    // ----------------------------------------------------------------
    // lookup port for the search engine, one cycle of latency
    // ----------------------------------------------------------------
    lkp_ok   = lkp_port_i < 3'(NUM_PORTS);
    lkp_idx  = {lkp_port_i, lkp_entry_i};
    lkp_word = lkp_ok ? mem[lkp_idx] : '0;                        // [R18]
    d.lkp_valid = lkp_ok;
    d.first  = lkp_word[aclrt_pkg::IA_FIRST_RULE][3:0];           // [R12] [R14]
    d.mode   = aclrt_pkg::aclrt_mode_t'(
      lkp_word[aclrt_pkg::IA_FILT_MODE][aclrt_pkg::MODE_LSB +: 2]);
    d.active = d.mode != aclrt_pkg::ACLRT_MODE_OFF;               // [R15]
    d.group  = {lkp_word[aclrt_pkg::IA_GROUP_HI],
                lkp_word[aclrt_pkg::IA_GROUP_LO]};                // [R13]
    d.ben    = {lkp_word[EB-2], lkp_word[EB-1]};                  // [R9]
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;                                                    // [R12]
    end else begin
      q <= d;
    end
  end

  // table clears on reset so lookups never see unknown words
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (mem_we) begin
      mem[mem_idx] <= q.stage[EB-1:0];                            // [R1]
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign bus.rdata          = q.rdata;
  assign lkp_valid_o        = q.lkp_valid;
  assign first_rule_index_o = q.first;
  assign filter_mode_o      = q.mode;
  assign filter_active_o    = q.active;
  assign rule_group_o       = q.group;
  assign byte_enable_o      = q.ben;
endmodule

// [verilog/aclrt_host.sv]
module aclrt_host (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  aclrt_bus_if.host         bus,
  input  wire logic         cmd_valid_i,
  input  wire logic         cmd_write_i,
  input  wire logic [3:0]   cmd_port_i,
  input  wire logic [7:0]   cmd_addr_i,
  input  wire logic [7:0]   cmd_wdata_i,
  output logic              cmd_ready_o,
  output logic              cmd_done_o,
  output logic [7:0]        cmd_rdata_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_PRE, S_CTL, S_ADR, S_DAT,
    S_RCTL, S_RADR, S_RDAT, S_CAP
  } aclrt_hst_st_t;

  typedef struct packed {
    aclrt_hst_st_t st;
    logic [7:0]    addr;
    logic [7:0]    wdata;
    logic          wr;
    logic          rd;
    logic          write;
    logic [3:0]    port;
    logic [7:0]    iadr;
    logic [7:0]    dat;
    logic          ready;
    logic          done;
    logic [7:0]    rdata;
  } aclrt_hst_state_t;

  aclrt_hst_state_t q;
  aclrt_hst_state_t d;
  logic [7:0]       ctl_byte;

  always_comb begin
    d        = q;
    d.wr     = 1'b0;
    d.rd     = 1'b0;
    d.done   = 1'b0;
    ctl_byte = {aclrt_pkg::SPACE_RULE,                            // [R11]
                q.write ? aclrt_pkg::DIR_WRITE : aclrt_pkg::DIR_READ,
                q.port};                                          // [R5] [R16]
    unique case (q.st)
      S_IDLE: begin
        if (cmd_valid_i) begin
          d.ready = 1'b0;
          d.write = cmd_write_i;
          d.port  = cmd_port_i;
          d.iadr  = cmd_addr_i;
          d.dat   = cmd_wdata_i;
          if (cmd_write_i) begin
            d.rd   = 1'b1;                                        // [R4]
            d.addr = aclrt_pkg::OFS_CTL_SEL;
            d.st   = S_PRE;
          end else begin
            d.wr    = 1'b1;                                       // [R3]
            d.addr  = aclrt_pkg::OFS_CTL_SEL;
            d.wdata = {aclrt_pkg::SPACE_RULE, aclrt_pkg::DIR_READ,
                       cmd_port_i};
            d.st    = S_CTL;
          end
        end
      end
      S_PRE: begin
        d.wr    = 1'b1;
        d.addr  = aclrt_pkg::OFS_CTL_SEL;
        d.wdata = ctl_byte;
        d.st    = S_CTL;
      end
      S_CTL: begin
        d.wr    = 1'b1;                                           // [R6] [R16]
        d.addr  = aclrt_pkg::OFS_ADR_TRIG;
        d.wdata = q.iadr;
        d.st    = S_ADR;
      end
      S_ADR: begin
        if (q.write) begin
          d.wr    = 1'b1;                                         // [R4]
          d.addr  = aclrt_pkg::OFS_DATA_BYTE;
          d.wdata = q.dat;
          d.st    = S_DAT;
        end else begin
          d.rd   = 1'b1;                                          // [R3]
          d.addr = aclrt_pkg::OFS_CTL_SEL;
          d.st   = S_RCTL;
        end
      end
      S_RCTL: begin
        d.rd   = 1'b1;
        d.addr = aclrt_pkg::OFS_ADR_TRIG;
        d.st   = S_RADR;
      end
      S_RADR: begin
        d.rd   = 1'b1;                                            // [R11]
        d.addr = aclrt_pkg::OFS_DATA_BYTE;
        d.st   = S_RDAT;
      end
      S_RDAT: begin
        d.st = S_CAP;
      end
      S_CAP: begin
        d.rdata = bus.rdata;
        d.done  = 1'b1;
        d.ready = 1'b1;
        d.st    = S_IDLE;
      end
      S_DAT: begin
        d.done  = 1'b1;
        d.ready = 1'b1;
        d.st    = S_IDLE;
      end
      default: begin
        d.st    = S_IDLE;
        d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q       <= '0;
      q.st    <= S_IDLE;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.addr    = q.addr;
  assign bus.wdata   = q.wdata;
  assign bus.wr      = q.wr;
  assign bus.rd      = q.rd;
  assign cmd_ready_o = q.ready;
  assign cmd_done_o  = q.done;
  assign cmd_rdata_o = q.rdata;
endmodule

// [test/aclrt_checker.sv]
module aclrt_checker #(
  parameter int NUM_PORTS = aclrt_pkg::NUM_PORTS
) (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // shadow of the control and trigger registers
  // ----------------------------------------------------------------
  logic [7:0] ctl_q;
  logic [7:0] ofs_q;
  logic       tbl_ok;
  logic       rd_dat;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_q <= 8'h00;
      ofs_q <= 8'h00;
    end else begin
      if (wr && addr == aclrt_pkg::OFS_CTL_SEL) ctl_q <= wdata;
      if (wr && addr == aclrt_pkg::OFS_ADR_TRIG) ofs_q <= wdata;
    end
  end
  assign tbl_ok = ctl_q[7:5] == aclrt_pkg::SPACE_RULE;
  assign rd_dat = rd && addr == aclrt_pkg::OFS_DATA_BYTE && tbl_ok;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  idle_zero_a: assert property (
    !rd |=> rdata == 8'h00) else $error("read data not idle");
  unmapped_zero_a: assert property (
    rd && !(addr inside {8'h6E, 8'h6F, 8'hA0}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  ctl_back_a: assert property (
    rd && addr == aclrt_pkg::OFS_CTL_SEL |=> rdata == ctl_q)
    else $error("control readback wrong");
  trig_back_a: assert property (
    rd && addr == aclrt_pkg::OFS_ADR_TRIG |=> rdata == ofs_q)
    else $error("trigger readback wrong");
  rsvd_zero_a: assert property (
    rd_dat && ofs_q inside {8'h0E, 8'h0F} |=> rdata == 8'h00)
    else $error("reserved entry byte not zero");
  first_mask_a: assert property (
    rd_dat && ofs_q == aclrt_pkg::IA_FIRST_RULE
    |=> (rdata & ~aclrt_pkg::MASK_FIRST) == 8'h00) else $error("bits 7:4");
  mode_mask_a: assert property (
    rd_dat && ofs_q == aclrt_pkg::IA_FILT_MODE
    |=> (rdata & ~aclrt_pkg::MASK_MODE) == 8'h00) else $error("mode bits");
  bad_port_a: assert property (
    rd_dat && ctl_q[3:0] >= NUM_PORTS |=> rdata == 8'h00)
    else $error("bad port read not zero");
  wr_seq_a: assert property (
    rd && addr == 8'h6E ##1 wr && addr == 8'h6E
    |-> wdata[7:4] == 4'h4 ##1 wr && addr == 8'h6F ##1 wr && addr == 8'hA0)
    else $error("entry write sequence wrong");
  rd_seq_a: assert property (
    wr && addr == 8'h6E && wdata[4] |-> wdata[7:5] == 3'h2 ##1
    wr && addr == 8'h6F ##1 rd && addr == 8'h6E ##1 rd && addr == 8'h6F
    ##1 rd && addr == 8'hA0) else $error("entry read sequence wrong");
endmodule

// [test/tb_acl_rule_table_indirect_access.sv]
module tb_acl_rule_table_indirect_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cmd_valid_i = 1'b0;
  logic        cmd_write_i = 1'b0;
  logic [3:0]  cmd_port_i = 4'h0;
  logic [7:0]  cmd_addr_i = 8'h00;
  logic [7:0]  cmd_wdata_i = 8'h00;
  logic [2:0]  lkp_port_i = 3'h0;
  logic [3:0]  lkp_entry_i = 4'h0;
  logic        cmd_ready_o, cmd_done_o, lkp_valid_o, filter_active_o;
  logic [7:0]  cmd_rdata_o;
  logic [3:0]  first_rule_index_o;
  logic [15:0] rule_group_o, byte_enable_o;
  aclrt_pkg::aclrt_mode_t filter_mode_o;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #2 mclk_i = ~mclk_i;
  aclrt_bus_if aclrt_bus_if_i ();
  aclrt_dev aclrt_dev_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .bus(aclrt_bus_if_i.dev), .lkp_port_i(lkp_port_i),
    .lkp_entry_i(lkp_entry_i), .lkp_valid_o(lkp_valid_o),
    .first_rule_index_o(first_rule_index_o), .filter_mode_o(filter_mode_o),
    .filter_active_o(filter_active_o), .rule_group_o(rule_group_o),
    .byte_enable_o(byte_enable_o));
  aclrt_host aclrt_host_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .bus(aclrt_bus_if_i.host), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_port_i(cmd_port_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o),
    .cmd_rdata_o(cmd_rdata_o));
  aclrt_checker aclrt_checker_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .addr(aclrt_bus_if_i.addr), .wdata(aclrt_bus_if_i.wdata),
    .wr(aclrt_bus_if_i.wr), .rd(aclrt_bus_if_i.rd),
    .rdata(aclrt_bus_if_i.rdata));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic w, input logic [3:0] p,
                     input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_write_i <= w;
    cmd_port_i  <= p;
    cmd_addr_i  <= a;
    cmd_wdata_i <= d;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
      // the host must drop ready once it has taken the command
      if (n == 1) begin
        chk(16'(cmd_ready_o), 16'h0000);
      end
    end while (cmd_done_o !== 1'b1 && n < 20);
    chk(16'(n), w ? 16'h0005 : 16'h0007);
    chk(16'(cmd_ready_o), 16'h0001);
  endtask
  task automatic rd(input logic [3:0] p, input logic [7:0] a,
                    input logic [7:0] e);
    cmd(1'b0, p, a, 8'h00);
    chk({8'h00, cmd_rdata_o}, {8'h00, e});
  endtask
  task automatic lkp(input logic [2:0] p, input logic [3:0] e);
    @(posedge mclk_i);
    lkp_port_i  <= p;
    lkp_entry_i <= e;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  function automatic logic [15:0] grp(input int p);
    return {4'(p), 4'hC, 8'(p) ^ 8'h3C};
  endfunction
  task automatic chk_all;
    for (int p = 0; p < aclrt_pkg::NUM_PORTS; p++) begin
      lkp(3'(p), 4'(15 - 3 * p));
      chk(16'(lkp_valid_o), 16'h0001);
      chk(16'(first_rule_index_o), 16'(p + 10));
      chk(16'(filter_mode_o), 16'(p % 4));
      chk(16'(filter_active_o), 16'(p % 4 != 0));
      chk(rule_group_o, grp(p));
      chk(byte_enable_o, ~grp(p));
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #40000;
    n_mismatch++;
    $display("ERROR t=%0t watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    lkp(3'h0, 4'h0);
    chk(16'(first_rule_index_o), 16'h0000);
    chk(16'(filter_mode_o), 16'h0000);
    rd(4'h0, aclrt_pkg::IA_FIRST_RULE, 8'h00);
    rd(4'h0, aclrt_pkg::IA_FILT_MODE, 8'h00);
    cmd(1'b1, 4'h0, aclrt_pkg::IA_FIRST_RULE, 8'hFF);
    rd(4'h0, aclrt_pkg::IA_FIRST_RULE, 8'h0F);
    cmd(1'b1, 4'h0, aclrt_pkg::IA_FILT_MODE, 8'hFF);
    rd(4'h0, aclrt_pkg::IA_FILT_MODE, 8'h30);
    cmd(1'b1, 4'h0, aclrt_pkg::IA_RSVD_HI, 8'hA5);
    rd(4'h0, aclrt_pkg::IA_RSVD_HI, 8'h00);
    rd(4'h0, aclrt_pkg::IA_RSVD_LO, 8'h00);
    // one entry per port, modes cycling through all four codes
    for (int p = 0; p < aclrt_pkg::NUM_PORTS; p++) begin
      cmd(1'b1, 4'(p), aclrt_pkg::IA_FIRST_RULE, 8'(p + 10));
      cmd(1'b1, 4'(p), aclrt_pkg::IA_FILT_MODE, 8'(p % 4) << 4);
      cmd(1'b1, 4'(p), aclrt_pkg::IA_GROUP_HI, 8'(grp(p) >> 8));
      cmd(1'b1, 4'(p), aclrt_pkg::IA_GROUP_LO, 8'(grp(p)));
      cmd(1'b1, 4'(p), 8'h10, ~8'(grp(p) >> 8));
      cmd(1'b1, 4'(p), 8'h11, ~8'(grp(p)));
      cmd(1'b1, 4'(p), aclrt_pkg::IA_ENTRY_CTL, 8'(16 + 15 - 3 * p));
    end
    chk_all();
    // reload a stored entry into staging and read it back
    cmd(1'b1, 4'h2, aclrt_pkg::IA_ENTRY_CTL, 8'h09);
    rd(4'h2, aclrt_pkg::IA_GROUP_HI, 8'(grp(2) >> 8));
    rd(4'h2, aclrt_pkg::IA_FIRST_RULE, 8'h0C);
    rd(4'h2, aclrt_pkg::IA_ENTRY_CTL, 8'h09);
    // modify one byte of the reloaded word and store it in a spare entry
    cmd(1'b1, 4'h2, aclrt_pkg::IA_FILT_MODE, 8'h30);
    cmd(1'b1, 4'h2, aclrt_pkg::IA_ENTRY_CTL, 8'h10);
    lkp(3'h2, 4'h0);
    chk(16'(filter_mode_o), 16'h0003);
    chk(16'(first_rule_index_o), 16'h000C);
    chk(rule_group_o, grp(2));
    // out-of-range port: refused, reads zero, tables untouched
    cmd(1'b1, 4'h5, aclrt_pkg::IA_ENTRY_CTL, 8'h13);
    cmd(1'b0, 4'h0, aclrt_pkg::IA_ENTRY_CTL, 8'h00);
    chk(16'(cmd_rdata_o[7]), 16'h0001);
    rd(4'h7, aclrt_pkg::IA_GROUP_HI, 8'h00);
    lkp(3'h5, 4'h3);
    chk(16'(lkp_valid_o), 16'h0000);
    chk_all();
    final_report();
  end
endmodule
